/* hrs_params.svh */
// Timing counts and field positions for the hub reset sequencer
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH
`define HRS_CLK_MHZ 25
`define HRS_T_HWRST_NS 1000
`define HRS_HWRST_CYC ((`HRS_T_HWRST_NS * `HRS_CLK_MHZ + 999) / 1000)
`define HRS_T_OPER_US 500
`define HRS_OPER_CYC (`HRS_T_OPER_US * `HRS_CLK_MHZ)
`define HRS_T_INACT_NS 1500
`define HRS_INACT_CYC (`HRS_T_INACT_NS * `HRS_CLK_MHZ / 1000)
`define HRS_T_ATTACH_NS 3000
`define HRS_ATTACH_CYC (`HRS_T_ATTACH_NS * `HRS_CLK_MHZ / 1000)
`define HRS_T_EEREAD_MS 40
`define HRS_EEREAD_CYC (`HRS_T_EEREAD_MS * `HRS_CLK_MHZ * 1000)
`define HRS_T_ATTWAIT_MS 100
`define HRS_ATTWAIT_CYC (`HRS_T_ATTWAIT_MS * `HRS_CLK_MHZ * 1000)
`define HRS_T_RST_HUB_MS 10
`define HRS_RST_HUB_CYC (`HRS_T_RST_HUB_MS * `HRS_CLK_MHZ * 1000)
`define HRS_T_RST_ROOT_MS 50
`define HRS_RST_ROOT_CYC (`HRS_T_RST_ROOT_MS * `HRS_CLK_MHZ * 1000)
`define HRS_T_RECOV_MS 10
`define HRS_RECOV_CYC (`HRS_T_RECOV_MS * `HRS_CLK_MHZ * 1000)
`define HRS_SEL_STRAP 2'h0
`define HRS_SEL_SMBUS 2'h1
`define HRS_STRAP_MASK 8'h0f
`define HRS_CFG_DEFAULT 8'h00
`define HRS_OFS_CTRL 4'h0
`define HRS_OFS_DATA 4'h4
`define HRS_OFS_CMD 4'h8
`define HRS_OFS_STATUS 4'hc
`define HRS_CTRL_START 0
`define HRS_CTRL_ROOT 1
`define HRS_CTRL_SEL_LO 2
`define HRS_CTRL_SMBDONE 4
`define HRS_CTRL_SUSP 5
`define HRS_CTRL_EEPRES 6
`define HRS_CMD_SETADDR 0
`define HRS_CMD_SETCFG 1
`endif

/* hrs_pkg.sv */
// Types shared by both ends of the hub reset sequencer
package hrs_pkg;
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_STAB = 3'b001,
        D_INACT = 3'b010,
        D_ATTDLY = 3'b011,
        D_EEREAD = 3'b100,
        D_SMBWAIT = 3'b101,
        D_RUN = 3'b110
    } hrs_dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_HWRST = 3'b001,
        H_WAITATT = 3'b010,
        H_ATTWAIT = 3'b011,
        H_BUSRST = 3'b100,
        H_RECOV = 3'b101,
        H_READY = 3'b110
    } hrs_host_state_t;
endpackage : hrs_pkg

/* hrs_link_if.sv */
// Link between the hub device end and the upstream/board end
`timescale 1ns/1ns
interface hrs_link_if;
    logic hw_reset_n;     // Hardware reset, active low
    logic [1:0] cfg_sel;  // Configuration select straps
    logic usb_attach;     // Device signals attach
    logic bus_reset;      // Upstream USB bus reset level
    logic set_addr;       // Pulse: load new USB address
    logic [6:0] addr;     // Address for set_addr
    logic set_config;     // Pulse: device configured
    logic suspend_req;    // Upstream suspend level
    logic eeprom_present; // EEPROM answered
    logic [7:0] eeprom_data; // Configuration byte from EEPROM
    logic smb_done;       // SMBus load finished
    logic [7:0] smb_data; // Configuration byte from SMBus
    modport dev (
        input hw_reset_n, cfg_sel, bus_reset, set_addr, addr, set_config,
        input suspend_req, eeprom_present, eeprom_data, smb_done, smb_data,
        output usb_attach
    );
    modport host (
        output hw_reset_n, cfg_sel, bus_reset, set_addr, addr, set_config,
        output suspend_req, eeprom_present, eeprom_data, smb_done, smb_data,
        input usb_attach
    );
endinterface : hrs_link_if

/* hrs_timer.sv */
// Down-counter giving a one-cycle pulse when a loaded delay ends
`timescale 1ns/1ns
module hrs_timer (
    input wire logic clk,          // 25 MHz clock
    input wire logic resetn,       // Async reset, active low
    input wire logic start,        // Load pulse
    input wire logic [23:0] load,  // Delay in cycles
    output logic done              // Pulse at delay end
);
    logic [23:0] count_reg;
    // Count down after a load
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count_reg <= 24'h00_0000;
        else if (start)
            count_reg <= load;
        else if (count_reg != 24'h00_0000)
            count_reg <= count_reg - 24'h00_0001;
    end
    // Pulse on the last counted cycle
    assign done = (count_reg == 24'h00_0001) && !start;
endmodule : hrs_timer

/* hrs_device.sv */
// Hub device end: hardware reset, configuration path, bus reset effects
`timescale 1ns/1ns
`include "hrs_params.svh"
module hrs_device #(
    parameter logic [23:0] OPER_CYC = 24'(`HRS_OPER_CYC),
    parameter logic [23:0] EEREAD_CYC = 24'(`HRS_EEREAD_CYC)
) (
    input wire logic clk,                       // 25 MHz clock
    input wire logic resetn,                    // Power-on reset, low
    hrs_link_if.dev link,                       // Upstream/board link
    input wire logic [7:0] strap_opts,          // Strap-option pins
    input wire logic [3:0] port_charging_enable, // Charging ports
    input wire logic port_reset_req,            // Local downstream reset
    output logic [3:0] downstream_port_power_en, // Port power
    output logic [3:0] downstream_port_reset,   // Downstream reset
    output logic phy_enable,                    // Transceivers on
    output logic diff_pair_oe,                  // Pairs driven
    output logic osc_pll_run,                   // Oscillator and PLL on
    output logic operational,                   // Start-up complete
    output logic [7:0] config_value,            // Loaded configuration
    output logic [6:0] usb_address,             // Current USB address
    output logic configured,                    // Configured state
    output logic suspended,                     // Suspend state
    output logic tt_clear                       // Clear TT buffers pulse
);
    logic rst_n;
    logic sync_a_reg;
    logic sync_b_reg;
    hrs_pkg::hrs_dev_state_t state_reg;
    logic tmr_start_reg;
    logic [23:0] tmr_load_reg;
    logic tmr_done;
    logic [7:0] config_reg;
    logic phy_reg;
    logic attach_reg;
    logic oper_reg;
    logic [6:0] addr_reg;
    logic cfgd_reg;
    logic susp_reg;
    logic bus_rst_d_reg;
    logic tt_clear_reg;
    logic [3:0] power_reg;
    logic [3:0] ds_reset_reg;

    // Merge strap pins with built-in defaults
    function automatic logic [7:0] strap_merge(input logic [7:0] pins);
        strap_merge = (pins & `HRS_STRAP_MASK) |
            (`HRS_CFG_DEFAULT & ~`HRS_STRAP_MASK);
    endfunction : strap_merge
    // Hardware reset acts at once on every flop
    assign rst_n = resetn & link.hw_reset_n;
    // Release synchroniser before counters start
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
        end
        else
        begin
            sync_a_reg <= 1'b1;
            sync_b_reg <= sync_a_reg;
        end
    end

    // Oscillator and PLL halted while in reset
    assign osc_pll_run = sync_b_reg;
    hrs_timer u_timer (
        .clk(clk),
        .resetn(rst_n),
        .start(tmr_start_reg),
        .load(tmr_load_reg),
        .done(tmr_done)
    );
    // Start-up sequence and configuration path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= hrs_pkg::D_IDLE;
            tmr_start_reg <= 1'b0;
            tmr_load_reg <= 24'h00_0000;
            config_reg <= `HRS_CFG_DEFAULT;
            phy_reg <= 1'b0;
            attach_reg <= 1'b0;
            oper_reg <= 1'b0;
        end
        else
        begin
            tmr_start_reg <= 1'b0;
            unique case (state_reg)
                hrs_pkg::D_IDLE:
                begin
                    if (sync_b_reg)
                    begin
                        tmr_start_reg <= 1'b1;
                        if (link.cfg_sel == `HRS_SEL_STRAP)
                        begin
                            tmr_load_reg <= 24'(`HRS_INACT_CYC);
                            state_reg <= hrs_pkg::D_INACT;
                        end
                        else
                        begin
                            tmr_load_reg <= OPER_CYC;
                            state_reg <= hrs_pkg::D_STAB;
                        end
                    end
                end
                hrs_pkg::D_STAB:
                begin
                    if (tmr_done)
                    begin
                        oper_reg <= 1'b1;
                        phy_reg <= 1'b1;
                        if (link.cfg_sel == `HRS_SEL_SMBUS)
                            state_reg <= hrs_pkg::D_SMBWAIT;
                        else
                        begin
                            tmr_start_reg <= 1'b1;
                            tmr_load_reg <= EEREAD_CYC;
                            state_reg <= hrs_pkg::D_EEREAD;
                        end
                    end
                end
                hrs_pkg::D_INACT:
                begin
                    if (tmr_done)
                    begin
                        oper_reg <= 1'b1;
                        phy_reg <= 1'b1;
                        config_reg <= strap_merge(strap_opts);
                        tmr_start_reg <= 1'b1;
                        tmr_load_reg <= 24'(`HRS_ATTACH_CYC);
                        state_reg <= hrs_pkg::D_ATTDLY;
                    end
                end
                hrs_pkg::D_ATTDLY:
                begin
                    if (tmr_done)
                    begin
                        attach_reg <= 1'b1;
                        state_reg <= hrs_pkg::D_RUN;
                    end
                end
                hrs_pkg::D_EEREAD:
                begin
                    if (tmr_done)
                    begin
                        if (link.eeprom_present)
                            config_reg <= link.eeprom_data;
                        else
                            config_reg <= 8'h00;
                        attach_reg <= 1'b1;
                        state_reg <= hrs_pkg::D_RUN;
                    end
                end
                hrs_pkg::D_SMBWAIT:
                begin
                    // No timeout: stays until the load is done
                    if (link.smb_done)
                    begin
                        config_reg <= link.smb_data;
                        attach_reg <= 1'b1;
                        state_reg <= hrs_pkg::D_RUN;
                    end
                end
                hrs_pkg::D_RUN:
                    attach_reg <= 1'b1;
                default:
                    state_reg <= hrs_pkg::D_IDLE;
            endcase
        end
    end

    // Bus reset edge detect
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_rst_d_reg <= 1'b0;
            tt_clear_reg <= 1'b0;
        end
        else
        begin
            bus_rst_d_reg <= link.bus_reset;
            tt_clear_reg <= link.bus_reset & ~bus_rst_d_reg;
        end
    end

    // Address, configuration and suspend state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= 7'h00;
            cfgd_reg <= 1'b0;
            susp_reg <= 1'b0;
        end
        else if (link.bus_reset)
        begin
            addr_reg <= 7'h00;
            cfgd_reg <= 1'b0;
            susp_reg <= 1'b0;
        end
        else if (attach_reg)
        begin
            if (link.set_addr)
                addr_reg <= link.addr;
            if (link.set_config)
                cfgd_reg <= 1'b1;
            susp_reg <= link.suspend_req;
        end
    end

    // Port power follows configuration
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            power_reg <= 4'h0;
        else if (link.bus_reset)
            power_reg <= 4'h0;
        else if (attach_reg && link.set_config)
            power_reg <= 4'hf;
    end

    // Downstream reset only from local request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ds_reset_reg <= 4'h0;
        else
            ds_reset_reg <= {4{port_reset_req & cfgd_reg}};
    end

    // Charging ports keep power through both resets
    assign downstream_port_power_en = power_reg | port_charging_enable;
    assign phy_enable = phy_reg;
    assign diff_pair_oe = phy_reg & attach_reg;
    assign operational = oper_reg;
    assign config_value = config_reg;
    assign usb_address = addr_reg;
    assign configured = cfgd_reg;
    assign suspended = susp_reg;
    assign tt_clear = tt_clear_reg;
    assign downstream_port_reset = ds_reset_reg;
    assign link.usb_attach = attach_reg;
endmodule : hrs_device

/* hrs_host.sv */
// Upstream/board end: drives hardware reset, straps and USB bus reset
`timescale 1ns/1ns
`include "hrs_params.svh"
module hrs_host #(
    parameter logic [23:0] ATTWAIT_CYC = 24'(`HRS_ATTWAIT_CYC),
    parameter logic [23:0] RST_HUB_CYC = 24'(`HRS_RST_HUB_CYC),
    parameter logic [23:0] RST_ROOT_CYC = 24'(`HRS_RST_ROOT_CYC),
    parameter logic [23:0] RECOV_CYC = 24'(`HRS_RECOV_CYC)
) (
    input wire logic clk,           // 25 MHz clock
    input wire logic resetn,        // Async reset, active low
    hrs_link_if.host link,          // Link to the hub device
    input wire logic [3:0] addr,    // Register byte address
    input wire logic [31:0] wdata,  // Write data
    input wire logic wr,            // Write strobe
    input wire logic rd,            // Read strobe
    output logic [31:0] rdata       // Read data, cycle after rd
);
    hrs_pkg::hrs_host_state_t state_reg;
    logic [6:0] ctrl_reg;
    logic [14:0] data_reg;
    logic set_addr_reg;
    logic set_cfg_reg;
    logic start_reg;
    logic tmr_start_reg;
    logic [23:0] tmr_load_reg;
    logic tmr_done;
    logic hw_rst_n_reg;
    logic bus_rst_reg;
    logic [31:0] rdata_reg;

    // Register writes; start and commands are one-cycle pulses
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg <= 7'h00;
            data_reg <= 15'h0000;
            set_addr_reg <= 1'b0;
            set_cfg_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            start_reg <= wr && addr == `HRS_OFS_CTRL &&
                wdata[`HRS_CTRL_START];
            set_addr_reg <= wr && addr == `HRS_OFS_CMD &&
                wdata[`HRS_CMD_SETADDR];
            set_cfg_reg <= wr && addr == `HRS_OFS_CMD &&
                wdata[`HRS_CMD_SETCFG];
            if (wr && addr == `HRS_OFS_CTRL)
                ctrl_reg <= {wdata[6:1], 1'b0};
            if (wr && addr == `HRS_OFS_DATA)
                data_reg <= wdata[14:0];
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_reg <= 32'h0000_0000;
        else if (rd)
        begin
            unique case (addr)
                `HRS_OFS_CTRL: rdata_reg <= {25'h000_0000, ctrl_reg};
                `HRS_OFS_DATA: rdata_reg <= {17'h0_0000, data_reg};
                `HRS_OFS_STATUS: rdata_reg <= {27'h000_0000,
                    state_reg == hrs_pkg::H_READY, state_reg, link.usb_attach};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
        else
            rdata_reg <= 32'h0000_0000;
    end

    hrs_timer u_timer (
        .clk(clk),
        .resetn(resetn),
        .start(tmr_start_reg),
        .load(tmr_load_reg),
        .done(tmr_done)
    );

    // Reset and attach sequence
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= hrs_pkg::H_IDLE;
            tmr_start_reg <= 1'b0;
            tmr_load_reg <= 24'h00_0000;
            hw_rst_n_reg <= 1'b0;
            bus_rst_reg <= 1'b0;
        end
        else
        begin
            tmr_start_reg <= 1'b0;
            if (start_reg)
            begin
                hw_rst_n_reg <= 1'b0;
                bus_rst_reg <= 1'b0;
                tmr_start_reg <= 1'b1;
                tmr_load_reg <= 24'(`HRS_HWRST_CYC);
                state_reg <= hrs_pkg::H_HWRST;
            end
            else
            begin
                unique case (state_reg)
                    hrs_pkg::H_IDLE:
                        hw_rst_n_reg <= 1'b0;
                    hrs_pkg::H_HWRST:
                    begin
                        if (tmr_done)
                        begin
                            hw_rst_n_reg <= 1'b1;
                            state_reg <= hrs_pkg::H_WAITATT;
                        end
                    end
                    hrs_pkg::H_WAITATT:
                    begin
                        if (link.usb_attach)
                        begin
                            tmr_start_reg <= 1'b1;
                            tmr_load_reg <= ATTWAIT_CYC;
                            state_reg <= hrs_pkg::H_ATTWAIT;
                        end
                    end
                    hrs_pkg::H_ATTWAIT:
                    begin
                        if (tmr_done)
                        begin
                            bus_rst_reg <= 1'b1;
                            tmr_start_reg <= 1'b1;
                            tmr_load_reg <= ctrl_reg[`HRS_CTRL_ROOT] ?
                                RST_ROOT_CYC : RST_HUB_CYC;
                            state_reg <= hrs_pkg::H_BUSRST;
                        end
                    end
                    hrs_pkg::H_BUSRST:
                    begin
                        if (tmr_done)
                        begin
                            bus_rst_reg <= 1'b0;
                            tmr_start_reg <= 1'b1;
                            tmr_load_reg <= RECOV_CYC;
                            state_reg <= hrs_pkg::H_RECOV;
                        end
                    end
                    hrs_pkg::H_RECOV:
                    begin
                        if (tmr_done)
                            state_reg <= hrs_pkg::H_READY;
                    end
                    hrs_pkg::H_READY:
                        bus_rst_reg <= 1'b0;
                    default:
                        state_reg <= hrs_pkg::H_IDLE;
                endcase
            end
        end
    end

    // Link drive; commands only after recovery
    assign link.hw_reset_n = hw_rst_n_reg;
    assign link.bus_reset = bus_rst_reg;
    assign link.cfg_sel = ctrl_reg[`HRS_CTRL_SEL_LO+1:`HRS_CTRL_SEL_LO];
    assign link.smb_done = ctrl_reg[`HRS_CTRL_SMBDONE];
    assign link.suspend_req = ctrl_reg[`HRS_CTRL_SUSP];
    assign link.eeprom_present = ctrl_reg[`HRS_CTRL_EEPRES];
    assign link.eeprom_data = data_reg[7:0];
    assign link.smb_data = data_reg[7:0];
    assign link.addr = data_reg[14:8];
    assign link.set_addr = set_addr_reg & (state_reg == hrs_pkg::H_READY);
    assign link.set_config = set_cfg_reg & (state_reg == hrs_pkg::H_READY);
    assign rdata = rdata_reg;
endmodule : hrs_host

/* hrs_link_assertions.sv */
// Assertions on the link and device outputs of the hub reset sequencer
`timescale 1ns/1ns
module hrs_link_checker #(
    parameter int OPER_CYC = 50 // Shortened start-up count
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset, low
    input wire logic hw_reset_n, // Hardware reset
    input wire logic [1:0] cfg_sel, // Select straps
    input wire logic usb_attach, // Attach
    input wire logic bus_reset, // Bus reset
    input wire logic smb_done, // Load done
    input wire logic [3:0] port_charging_enable, // Charging
    input wire logic port_reset_req, // Local reset
    input wire logic [3:0] downstream_port_power_en, // Power
    input wire logic [3:0] downstream_port_reset, // Port reset
    input wire logic phy_enable, // PHY on
    input wire logic osc_pll_run, // Clocking on
    input wire logic operational, // Ready
    input wire logic [6:0] usb_address, // Address
    input wire logic configured, // Configured
    input wire logic suspended, // Suspended
    input wire logic tt_clear // TT clear
);
    localparam int OPER_LIM = OPER_CYC + 45;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Hardware reset keeps the device quiet
    attach_rst_a: assert property (!hw_reset_n |-> !usb_attach)
        else $error("attach high in hardware reset");
    rst_quiet_a: assert property (!hw_reset_n |->
        !phy_enable && !osc_pll_run)
        else $error("phy or clocking on in hardware reset");
    power_rst_a: assert property (!hw_reset_n |->
        downstream_port_power_en == port_charging_enable)
        else $error("port power wrong in hardware reset");
    // Start-up timing after release
    op_ready_a: assert property ($rose(hw_reset_n) |->
        ##[1:OPER_LIM] operational)
        else $error("not operational in time");
    strap_attach_a: assert property ($rose(hw_reset_n) &&
        cfg_sel == 2'h0 |-> ##[100:130] usb_attach)
        else $error("strap attach out of window");
    smb_wait_a: assert property ($rose(usb_attach) &&
        cfg_sel == 2'h1 |-> $past(smb_done))
        else $error("attach before load done");
    // Bus reset side effects
    bus_clear_a: assert property (bus_reset && hw_reset_n |=>
        usb_address == 7'h00 && !configured && !suspended)
        else $error("bus reset left address or state");
    bus_power_a: assert property (bus_reset && hw_reset_n |=>
        downstream_port_power_en == port_charging_enable)
        else $error("bus reset left port power");
    tt_pulse_a: assert property ($rose(bus_reset) && hw_reset_n
        |=> tt_clear ##1 !tt_clear)
        else $error("no single tt clear pulse");
    no_forward_a: assert property (bus_reset && !port_reset_req
        |=> downstream_port_reset == 4'h0)
        else $error("bus reset forwarded downstream");
endmodule : hrs_link_checker

/* hub_reset_config_sequencer_tb.sv */
// Self-checking bench for the hub reset sequencer
`timescale 1ns/1ns
module hub_reset_config_sequencer_tb;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic port_reset_req = 1'b0, operational, configured, suspended;
    logic tt_clear, phy_enable, osc_pll_run, diff_pair_oe;
    logic [3:0] addr = 4'h0, port_charging_enable = 4'h5;
    logic [3:0] downstream_port_power_en, downstream_port_reset;
    logic [7:0] strap_opts = 8'h5a, config_value;
    logic [6:0] usb_address;
    logic [31:0] wdata = 32'h0, rdata, d;
    int error_cnt = 0, checks = 0;
    hrs_link_if lnk();
    hrs_device #(.OPER_CYC(24'd50), .EEREAD_CYC(24'd100)) i_hrs_device (
        .clk(clk), .resetn(resetn), .link(lnk), .strap_opts(strap_opts),
        .port_charging_enable(port_charging_enable),
        .port_reset_req(port_reset_req), .phy_enable(phy_enable),
        .downstream_port_power_en(downstream_port_power_en),
        .downstream_port_reset(downstream_port_reset), .tt_clear(tt_clear),
        .diff_pair_oe(diff_pair_oe), .osc_pll_run(osc_pll_run),
        .operational(operational), .config_value(config_value),
        .usb_address(usb_address), .configured(configured),
        .suspended(suspended));
    hrs_host #(.ATTWAIT_CYC(24'd40), .RST_HUB_CYC(24'd20),
        .RST_ROOT_CYC(24'd30), .RECOV_CYC(24'd20)) i_hrs_host (
        .clk(clk), .resetn(resetn), .link(lnk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    hrs_link_checker i_hrs_link_checker (
        .clk(clk), .resetn(resetn), .hw_reset_n(lnk.hw_reset_n),
        .cfg_sel(lnk.cfg_sel), .usb_attach(lnk.usb_attach),
        .bus_reset(lnk.bus_reset), .smb_done(lnk.smb_done),
        .port_charging_enable(port_charging_enable),
        .port_reset_req(port_reset_req), .phy_enable(phy_enable),
        .downstream_port_power_en(downstream_port_power_en),
        .downstream_port_reset(downstream_port_reset), .tt_clear(tt_clear),
        .osc_pll_run(osc_pll_run), .operational(operational),
        .usb_address(usb_address), .configured(configured),
        .suspended(suspended));
    // Clock
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // One full start-up, bus reset and configuration pass
    task automatic run_mode(input logic [31:0] ctrl, input logic [31:0] dat,
        input logic [7:0] cfg);
        int n;
        n = 0;
        wr_reg(4'h4, dat);
        wr_reg(4'h0, ctrl | 32'h1);
        repeat (4) @(posedge clk);
        #1 chk({osc_pll_run, phy_enable, diff_pair_oe, configured, suspended,
            usb_address}, 32'h0);
        chk(downstream_port_power_en, port_charging_enable);
        if (ctrl[3:2] == 2'b01)
        begin
            repeat (300) @(posedge clk);
            rd_reg(4'hc);
            chk(d, {27'h0, 1'b0, hrs_pkg::H_WAITATT, 1'b0});
            wr_reg(4'h0, ctrl | 32'h10);
        end
        rd_reg(4'hc);
        while (d[4] !== 1'b1 && n < 3000)
        begin
            rd_reg(4'hc);
            n++;
        end
        chk(d, {27'h0, 1'b1, hrs_pkg::H_READY, 1'b1});
        chk(config_value, cfg);
        rd_reg(4'h4);
        chk(d, dat);
        wr_reg(4'h8, 32'h3);
        repeat (3) @(posedge clk);
        #1 chk({configured, usb_address}, {1'b1, dat[14:8]});
        chk(downstream_port_power_en, 4'hf);
        chk({phy_enable, diff_pair_oe, operational}, 32'h7);
        chk(osc_pll_run, 32'h1);
    endtask : run_mode
    task automatic results();
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    // Main sequence: strap, EEPROM, absent EEPROM, SMBus
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        strap_opts <= 8'hc6;
        rd_reg(4'h2);
        chk(d, 32'h0);
        run_mode(32'h0000_0000, 32'h0000_2b77, 8'h06);
        @(posedge clk);
        port_charging_enable <= 4'h2;
        run_mode(32'h0000_006a, 32'h0000_1ca5, 8'ha5);
        run_mode(32'h0000_000c, 32'h0000_33c3, 8'h00);
        // Mid-run power-on reset clears both ends
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        rd_reg(4'h0);
        chk(d, 32'h0);
        chk({config_value, usb_address, configured}, 32'h0);
        run_mode(32'h0000_0004, 32'h0000_453c, 8'h3c);
        @(posedge clk);
        port_reset_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(downstream_port_reset, 4'hf);
        @(posedge clk);
        port_reset_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(downstream_port_reset, 4'h0);
        results();
    end
endmodule : hub_reset_config_sequencer_tb
